// *** ebp_bridge_pwm.sv ***
// Enhanced bridge modulator output stage with APB registers
// Operation
// - All period timing is counted from the system clock.
// - Reset clears modulator registers and turns every pin into an input.
// - Arrangement code 00 single, 10 half, 01 forward, 11 reverse bridge.
// - Half bridge uses A and B, full bridge all four; others stay port pins.
// - Two bits pick active-low or active-high for pairs A/C and B/D.
// - After enabling, no waveform appears until a new period starts.
// - Writing zero to mode control releases every output pin to the port.
// - Half bridge drives the waveform on A and its complement on B.
// - Half bridge delays each rising active edge by a count of instruction cycles.
// - Dead band longer than the active time keeps that output inactive.
// - Forward drives A active, modulates D, holds B and C inactive.
// - Reverse drives C active, modulates B, holds A and D inactive.
// - Direction flip takes effect next period; modulation blanks, fixed outputs swap first.
// - The swap happens prescale oscillator cycles before the period ends.
// - Full bridge modes have no dead band.
// - Shutdown comes from interrupt pin low, comparators, or software setting status.
// - Status reads one while outputs are shut down, zero otherwise.
// - A shutdown event sets status until software or auto restart clears it.
// - Shutdown forces each enabled pair high, low or floating without the clock.
// - Source code selects comparator one, two, either, and interrupt pin combinations.
// - Pair safe code 00 low, 01 high, 1x high impedance.
// - Auto restart keeps status while the condition lasts, then clears it.
// - Condition is a level; status writes ignored while it lasts; output resumes at next period.
`timescale 1ns/1ps
`default_nettype none
module ebp_bridge_pwm
    import ebp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Shutdown sources
    input  wire logic        comparator_one,
    input  wire logic        comparator_two,
    input  wire logic        int_pin_n,
    // Port latch data for pins not under modulator control
    input  wire logic [3:0]  port_out,
    // Pins, index 0 output_a to 3 output_d
    output logic [3:0]       pin_out,
    output logic [3:0]       pin_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Registers
    logic [7:0]  mode_ctl_q;
    logic [7:0]  duty_high_byte_q;
    logic [7:0]  period_limit_q;
    logic [2:0]  tmr_ctl_q;
    logic [7:0]  dead_band_control_q;
    logic [6:0]  sd_ctl_q;
    logic        shutdown_status_q;
    logic        period_timer_flag_q;
    logic [3:0]  pin_direction_bit_q;
    logic [31:0] prdata_q;
    // Time base and output state
    logic [7:0]  period_timer_count_q;
    logic [5:0]  psc_q;
    logic [1:0]  tcy_q;
    logic [9:0]  duty_q;
    logic        dir_q;
    ebp_state_e  st_q;
    ebp_state_e  st_d;
    logic [1:0]  db_q;

    // Register fields
    wire [3:0] unit_mode_select          = mode_ctl_q[3:0];
    wire [1:0] duty_low_bits             = mode_ctl_q[MODE_DLO_LSB +: 2];
    wire [1:0] output_arrangement_select = mode_ctl_q[MODE_ARR_LSB +: 2];
    wire [1:0] period_timer_prescale     = tmr_ctl_q[1:0];
    wire       period_timer_run          = tmr_ctl_q[TCTRL_RUN];
    wire [6:0] dead_band_count           = dead_band_control_q[6:0];
    wire       auto_restart_enable       = dead_band_control_q[DB_RESTART];
    wire [2:0] shutdown_source_select    = sd_ctl_q[SD_SRC_LSB +: 3];
    wire [1:0] pair_ac_safe_state        = sd_ctl_q[SD_AC_LSB +: 2];
    wire [1:0] pair_bd_safe_state        = sd_ctl_q[1:0];

    // APB decode
    wire acc    = psel && penable;
    wire wr     = acc && pwrite;
    wire wr_mode = wr && paddr == ADDR_MODE;
    wire wr_sd  = wr && paddr == ADDR_SDCTL;
    wire hit    = paddr == ADDR_MODE || paddr == ADDR_DUTY || paddr == ADDR_PERIOD
               || paddr == ADDR_TCTRL || paddr == ADDR_TCOUNT || paddr == ADDR_DBAND
               || paddr == ADDR_SDCTL || paddr == ADDR_FLAG || paddr == ADDR_PINDIR;
    wire [7:0] rd_byte =
          paddr == ADDR_MODE   ? mode_ctl_q
        : paddr == ADDR_DUTY   ? duty_high_byte_q
        : paddr == ADDR_PERIOD ? period_limit_q
        : paddr == ADDR_TCTRL  ? {5'h00, tmr_ctl_q}
        : paddr == ADDR_TCOUNT ? period_timer_count_q
        : paddr == ADDR_DBAND  ? dead_band_control_q
        : paddr == ADDR_SDCTL  ? {shutdown_status_q, sd_ctl_q}
        : paddr == ADDR_FLAG   ? {7'h00, period_timer_flag_q}
        : paddr == ADDR_PINDIR ? {4'h0, pin_direction_bit_q}
        : 8'h00;
    assign pready  = 1'b1;
    assign pslverr = acc && !hit;
    assign prdata  = prdata_q;

    // Time base
    wire [5:0] psc_lim = period_timer_prescale == PSC_1 ? PSC_LIM_1
                       : period_timer_prescale == PSC_4 ? PSC_LIM_4 : PSC_LIM_16;
    wire [5:0] psc_val = period_timer_prescale == PSC_1 ? PSC_VAL_1
                       : period_timer_prescale == PSC_4 ? PSC_VAL_4 : PSC_VAL_16;
    wire [1:0] sub  = period_timer_prescale == PSC_1 ? psc_q[1:0]
                    : period_timer_prescale == PSC_4 ? psc_q[3:2] : psc_q[5:4];
    wire tmr_tick   = period_timer_run && psc_q == psc_lim;
    wire at_limit   = period_timer_count_q == period_limit_q;
    wire pstart     = tmr_tick && at_limit;
    wire tcy_tick   = tcy_q == TCY_LAST;
    wire raw        = {period_timer_count_q, sub} < duty_q;

    // Mode decode
    wire pwm_en   = unit_mode_select[3:2] == UNIT_PWM;
    wire is_half  = output_arrangement_select == ARR_HALF;
    wire is_full  = output_arrangement_select[0];
    wire turn_pt  = is_full && st_q == ST_RUN && output_arrangement_select[1] != dir_q
                 && period_timer_run && at_limit
                 && psc_q == 6'(psc_lim - psc_val);
    wire live     = st_q == ST_RUN || st_q == ST_TURN;
    wire mod      = raw && st_q == ST_RUN;

    // Shutdown
    wire sd_cond = (shutdown_source_select[0] && comparator_one)
                || (shutdown_source_select[1] && comparator_two)
                || (shutdown_source_select[2] && !int_pin_n);
    wire sd_act  = sd_cond || shutdown_status_q;

    // Output levels, active high before polarity
    wire [1:0] hb_src = {live && !raw, mod};
    wire [3:0] lvl =
          is_full ? {mod && !dir_q, live && dir_q, mod && dir_q, live && !dir_q}
        : is_half ? {2'b00, db_q}
        : {3'b000, mod};
    wire [3:0] used  = !pwm_en ? 4'h0 : is_full ? 4'hf : is_half ? 4'h3 : 4'h1;
    wire [3:0] inv   = {unit_mode_select[0], unit_mode_select[1],
                        unit_mode_select[0], unit_mode_select[1]};
    wire [3:0] safe_hi  = {pair_bd_safe_state == SAFE_HIGH, pair_ac_safe_state == SAFE_HIGH,
                           pair_bd_safe_state == SAFE_HIGH, pair_ac_safe_state == SAFE_HIGH};
    wire [3:0] safe_tri = {pair_bd_safe_state[1], pair_ac_safe_state[1],
                           pair_bd_safe_state[1], pair_ac_safe_state[1]};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            assign pin_out[gi] = !used[gi] ? port_out[gi]
                               : sd_act ? safe_hi[gi]
                               : lvl[gi] ^ inv[gi];
            assign pin_oe[gi]  = !pin_direction_bit_q[gi]
                              && !(used[gi] && sd_act && safe_tri[gi]);
        end
        for (gi = 0; gi < 2; gi++) begin : g_db
            ebp_dead_band u_db (
                .clk             (clk),
                .rst             (rst),
                .raw             (hb_src[gi]),
                .tcy_tick        (tcy_tick),
                .dead_band_count (dead_band_count),
                .out_q           (db_q[gi])
            );
        end
    endgenerate

    // Output phase
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_WAIT: if (pstart) st_d = ST_RUN;
            ST_RUN:  if (turn_pt) st_d = ST_TURN;
            ST_TURN: if (pstart) st_d = ST_RUN;
            ST_HALT: if (pstart && !shutdown_status_q) st_d = ST_RUN;
            default: st_d = ST_WAIT;
        endcase
        if (sd_act) st_d = ST_HALT;
        if (!pwm_en) st_d = ST_WAIT;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q  <= ST_WAIT;
            dir_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (turn_pt || !is_full || st_q != ST_RUN) begin
                dir_q <= output_arrangement_select[1];
            end
        end
    end

    // Timer and duty latch
    always_ff @(posedge clk) begin
        if (rst) begin
            psc_q                <= 6'h00;
            tcy_q                <= 2'h0;
            period_timer_count_q <= REG_RST;
            duty_q               <= 10'h000;
        end else begin
            tcy_q <= pstart ? 2'h0 : tcy_q + 2'h1;
            if (period_timer_run) begin
                psc_q <= tmr_tick ? 6'h00 : psc_q + 6'h01;
            end
            if (pstart) begin
                period_timer_count_q <= REG_RST;
                duty_q <= {duty_high_byte_q, duty_low_bits};
            end else if (tmr_tick) begin
                period_timer_count_q <= period_timer_count_q + 8'h01;
            end
        end
    end

    // Registers written by software
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_ctl_q          <= REG_RST;
            duty_high_byte_q    <= REG_RST;
            period_limit_q      <= REG_RST;
            tmr_ctl_q           <= 3'h0;
            dead_band_control_q <= REG_RST;
            sd_ctl_q            <= 7'h00;
            pin_direction_bit_q <= PINDIR_RST;
            prdata_q            <= 32'h0000_0000;
        end else begin
            prdata_q <= (psel && !penable && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            if (wr_mode) mode_ctl_q <= pwdata[7:0];
            if (wr && paddr == ADDR_DUTY) duty_high_byte_q <= pwdata[7:0];
            if (wr && paddr == ADDR_PERIOD) period_limit_q <= pwdata[7:0];
            if (wr && paddr == ADDR_TCTRL) tmr_ctl_q <= pwdata[2:0];
            if (wr && paddr == ADDR_DBAND) dead_band_control_q <= pwdata[7:0];
            if (wr_sd) sd_ctl_q <= pwdata[6:0];
            if (wr && paddr == ADDR_PINDIR) pin_direction_bit_q <= pwdata[3:0];
        end
    end

    // Flags set by hardware; the set wins over a write
    always_ff @(posedge clk) begin
        if (rst) begin
            shutdown_status_q   <= 1'b0;
            period_timer_flag_q <= 1'b0;
        end else begin
            if (sd_cond) begin
                shutdown_status_q <= 1'b1;
            end else if (wr_sd) begin
                shutdown_status_q <= pwdata[SD_STATUS];
            end else if (auto_restart_enable) begin
                shutdown_status_q <= 1'b0;
            end
            if (pstart) begin
                period_timer_flag_q <= 1'b1;
            end else if (wr && paddr == ADDR_FLAG) begin
                period_timer_flag_q <= pwdata[0];
            end
        end
    end

    // Checks
    sequence turn_s;
        turn_pt ##1 (st_q == ST_TURN && !lvl[1] && !lvl[3]);
    endsequence

    reset_pins_a : assert property ($fell(rst) |-> pin_oe == 4'h0)
        else $error("pins not inputs after reset");
    mode_zero_a : assert property (mode_ctl_q == REG_RST |-> pin_out == port_out)
        else $error("pins held with mode cleared");
    wait_period_a : assert property (st_q == ST_WAIT |-> !mod ##1 (st_q != ST_RUN || $past(pstart)))
        else $error("waveform before period start");
    fwd_levels_a : assert property (is_full && !dir_q && st_q == ST_RUN && !sd_act
        |-> lvl[0] && !lvl[1] && !lvl[2])
        else $error("forward levels wrong");
    rev_levels_a : assert property (is_full && dir_q && st_q == ST_RUN && !sd_act
        |-> lvl[2] && !lvl[0] && !lvl[3])
        else $error("reverse levels wrong");
    turn_blank_a : assert property (turn_pt |-> at_limit and turn_s)
        else $error("direction turn wrong");
    sd_set_a : assert property (sd_cond |=> shutdown_status_q)
        else $error("shutdown status not set");
    sd_force_a : assert property (sd_act && used[0] && !safe_tri[0]
        |-> pin_out[0] == safe_hi[0])
        else $error("safe state not driven");
    restart_clr_a : assert property (auto_restart_enable && shutdown_status_q && !sd_cond
        && !wr_sd |=> !shutdown_status_q)
        else $error("auto restart did not clear");
    period_wrap_a : assert property (pstart |=> period_timer_count_q == 8'h00
        && period_timer_flag_q)
        else $error("period did not wrap");
endmodule : ebp_bridge_pwm
`default_nettype wire

// *** ebp_pkg.sv ***
// Constants for the enhanced bridge modulator output stage
package ebp_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_MODE   = 8'h00;
    localparam logic [7:0] ADDR_DUTY   = 8'h04;
    localparam logic [7:0] ADDR_PERIOD = 8'h08;
    localparam logic [7:0] ADDR_TCTRL  = 8'h0c;
    localparam logic [7:0] ADDR_TCOUNT = 8'h10;
    localparam logic [7:0] ADDR_DBAND  = 8'h14;
    localparam logic [7:0] ADDR_SDCTL  = 8'h18;
    localparam logic [7:0] ADDR_FLAG   = 8'h1c;
    localparam logic [7:0] ADDR_PINDIR = 8'h20;
    // Reset values
    localparam logic [7:0] REG_RST     = 8'h00;
    localparam logic [3:0] PINDIR_RST  = 4'hf;
    // Field codes
    localparam logic [1:0] UNIT_PWM    = 2'h3;
    localparam logic [1:0] ARR_SINGLE  = 2'h0;
    localparam logic [1:0] ARR_HALF    = 2'h2;
    localparam logic [1:0] ARR_FWD     = 2'h1;
    localparam logic [1:0] ARR_REV     = 2'h3;
    localparam logic [1:0] SAFE_HIGH   = 2'h1;
    localparam logic [1:0] PSC_1       = 2'h0;
    localparam logic [1:0] PSC_4       = 2'h1;
    // Field positions
    localparam int MODE_ARR_LSB  = 6;
    localparam int MODE_DLO_LSB  = 4;
    localparam int TCTRL_RUN     = 2;
    localparam int DB_RESTART    = 7;
    localparam int SD_STATUS     = 7;
    localparam int SD_SRC_LSB    = 4;
    localparam int SD_AC_LSB     = 2;
    // Timing counts, in oscillator cycles
    localparam int         TCY_CLKS    = 4;
    localparam logic [1:0] TCY_LAST    = 2'(TCY_CLKS - 1);
    localparam logic [5:0] PSC_LIM_1   = 6'(TCY_CLKS * 1 - 1);
    localparam logic [5:0] PSC_LIM_4   = 6'(TCY_CLKS * 4 - 1);
    localparam logic [5:0] PSC_LIM_16  = 6'(TCY_CLKS * 16 - 1);
    localparam logic [5:0] PSC_VAL_1   = 6'h01;
    localparam logic [5:0] PSC_VAL_4   = 6'h04;
    localparam logic [5:0] PSC_VAL_16  = 6'h10;
    // Output phase
    typedef enum logic [3:0] {
        ST_WAIT = 4'b0001,
        ST_RUN  = 4'b0010,
        ST_TURN = 4'b0100,
        ST_HALT = 4'b1000
    } ebp_state_e;
endpackage : ebp_pkg

// *** ebp_dead_band.sv ***
// Dead-band delay of one inactive-to-active transition
`timescale 1ns/1ps
`default_nettype none
module ebp_dead_band
    import ebp_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Control
    input  wire logic       raw,
    input  wire logic       tcy_tick,
    input  wire logic [6:0] dead_band_count,
    // Delayed level
    output logic            out_q
);
    logic [6:0] cnt_q;
    wire        reached = (cnt_q >= dead_band_count);

    always_ff @(posedge clk) begin
        if (rst || !raw) begin
            cnt_q <= 7'h00;
            out_q <= 1'b0;
        end else if (!out_q) begin
            if (reached) begin
                out_q <= 1'b1;
            end else if (tcy_tick) begin
                cnt_q <= cnt_q + 7'h01;
            end
        end
    end

    db_hold_a : assert property (@(posedge clk) disable iff (rst)
        $rose(raw) && dead_band_count != 7'h00 |=> !out_q)
        else $error("dead band released too early");
endmodule : ebp_dead_band
`default_nettype wire

// *** ebp_switch_model.sv ***
// Model of the external power switch drivers on the four bridge pins
`timescale 1ns/1ps
`default_nettype none
module ebp_switch_model (
    // Pins from the output stage
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    // Gate levels seen by the power switches
    output logic [3:0]      gate
);
    // Released pins sit on pull-downs, keeping their switches off
    assign gate = pin_out & pin_oe;
endmodule : ebp_switch_model
`default_nettype wire

// *** ebp_bridge_pwm_test.sv ***
// Self-checking bench for the bridge modulator output stage
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module ebp_bridge_pwm_test
    import ebp_pkg::*;
;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, c_one, c_two, int_n;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  port_out, pin_out, pin_oe, gate;
    logic [32:0] expq[$];
    logic [32:0] ex;
    logic [1:0]  arr, pol;
    logic [6:0]  db;
    logic [1:0]  tbl[4] = '{ARR_SINGLE, ARR_HALF, ARR_FWD, ARR_REV};
    int          mismatches, n_checks, seed, act[4], both, d, w, win, lo;

    ebp_bridge_pwm u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comparator_one(c_one), .comparator_two(c_two),
        .int_pin_n(int_n), .port_out(port_out), .pin_out(pin_out), .pin_oe(pin_oe));
    ebp_switch_model u_sw (.pin_out(pin_out), .pin_oe(pin_oe), .gate(gate));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results

    task automatic apb(input logic wrt, input logic [7:0] a, input logic [7:0] dat);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wrt;
        paddr <= a;
        pwdata <= {24'h0, dat};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            mismatches++;
            results();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        apb(1'b1, a, dat);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic err);
        expq.push_back({err, 24'h0, e});
        apb(1'b0, a, 8'h00);
    endtask : rd

    // Read results are compared in order of issue
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite) begin
            if (expq.size() == 0) begin
                mismatches++;
                $display("[ERR] prdata exp none got %h", prdata);
            end else begin
                ex = expq.pop_front();
                `CHK("prdata", ex, {pslverr, prdata})
            end
        end
    end

    task automatic do_reset();
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : do_reset

    task automatic setup(input logic [1:0] ar, input logic [1:0] pl, input logic [1:0] psc);
        wr(ADDR_PINDIR, 8'h0f);
        wr(ADDR_PERIOD, 8'h07);
        wr(ADDR_MODE, {ar, 2'(d), 2'b11, pl});
        wr(ADDR_DUTY, 8'(d >> 2));
        wr(ADDR_DBAND, {1'b0, db});
        wr(ADDR_FLAG, 8'h01);
        wr(ADDR_TCTRL, {5'h0, 1'b1, psc});
        repeat (64 * (psc == PSC_4 ? 4 : 1)) @(posedge clk);
        wr(ADDR_PINDIR, 8'h00);
    endtask : setup

    task automatic measure(input int n, input logic [3:0] lv);
        act = '{default: 0};
        both = 0;
        repeat (n) begin
            @(negedge clk);
            for (int i = 0; i < 4; i++) act[i] += int'(gate[i] === lv[i]);
            both += int'(gate[0] === lv[0] && gate[1] === lv[1]);
        end
        @(posedge clk);
    endtask : measure

    initial begin
        seed = 51;
        mismatches = 0;
        n_checks = 0;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {c_one, c_two, int_n} = 3'b001;
        port_out = 4'($random(seed));
        do_reset();
        `CHK("rst_oe", 4'h0, pin_oe)
        `CHK("rst_pins", port_out, pin_out)
        for (int a = 0; a <= 32; a += 4) begin
            rd(8'(a), (8'(a) == ADDR_PINDIR) ? {4'h0, PINDIR_RST} : REG_RST, 1'b0);
        end
        rd(8'h24, 8'h00, 1'b1);
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                arr = tbl[m];
                d = 4 + {$random(seed)} % 24;
                pol = 2'($random(seed));
                db = (m == 1) ? (p == 1 ? 7'h7f : 7'(d / 8)) : 7'h00;
                w = d * (p == 1 ? 4 : 1);
                win = 32 * (p == 1 ? 4 : 1);
                lo = w - 4 * int'(db) - 1;
                setup(arr, pol, p == 1 ? PSC_4 : PSC_1);
                measure(win, {~pol[0], ~pol[1], ~pol[0], ~pol[1]});
                case (m)
                    0: `CHK("single_a", w, act[0])
                    1: begin
                        `CHK("half_a", 1'b1, (lo < 0) ? act[0] == 0 : act[0] inside {[lo:lo + 1]})
                        `CHK("half_ab", 0, both)
                    end
                    2: `CHK("fwd", {win, 32'd0, 32'd0, w}, {act[0], act[1], act[2], act[3]})
                    default: `CHK("rev", {32'd0, w, win, 32'd0}, {act[0], act[1], act[2], act[3]})
                endcase
            end
        end
        d = 8;
        db = 7'h00;
        setup(ARR_FWD, 2'b00, PSC_1);
        wr(ADDR_SDCTL, 8'h16);
        c_one <= 1'b1;
        @(negedge clk);
        `CHK("sd_gate", 4'b0101, gate)
        `CHK("sd_oe", 2'b00, {pin_oe[3], pin_oe[1]})
        @(posedge clk);
        rd(ADDR_SDCTL, 8'h96, 1'b0);
        wr(ADDR_SDCTL, 8'h16);
        rd(ADDR_SDCTL, 8'h96, 1'b0);
        c_one <= 1'b0;
        repeat (3) @(posedge clk);
        rd(ADDR_SDCTL, 8'h96, 1'b0);
        wr(ADDR_SDCTL, 8'h16);
        rd(ADDR_SDCTL, 8'h16, 1'b0);
        wr(ADDR_SDCTL, 8'h86);
        rd(ADDR_SDCTL, 8'h86, 1'b0);
        wr(ADDR_SDCTL, 8'h06);
        wr(ADDR_DBAND, 8'h80);
        for (int code = 0; code < 8; code++) begin
            for (int s = 0; s < 3; s++) begin
                wr(ADDR_SDCTL, {1'b0, 3'(code), 4'h0});
                {int_n, c_two, c_one} <= {s != 2, s == 1, s == 0};
                repeat (2) @(posedge clk);
                rd(ADDR_SDCTL, {code[s], 3'(code), 4'h0}, 1'b0);
                {int_n, c_two, c_one} <= 3'b100;
                repeat (3) @(posedge clk);
                rd(ADDR_SDCTL, {1'b0, 3'(code), 4'h0}, 1'b0);
            end
        end
        wr(ADDR_SDCTL, 8'h00);
        wr(ADDR_MODE, 8'h00);
        @(negedge clk);
        `CHK("release", port_out, pin_out)
        @(posedge clk);
        do_reset();
        rd(ADDR_MODE, REG_RST, 1'b0);
        rd(ADDR_PINDIR, {4'h0, PINDIR_RST}, 1'b0);
        repeat (2) @(posedge clk);
        if (expq.size() != 0) mismatches++;
        results();
    end
endmodule : ebp_bridge_pwm_test
`default_nettype wire
